/* cab_defines.vh */
`ifndef CAB_DEFINES_VH
`define CAB_DEFINES_VH

// ==========================================================
// Operation codes
`define CAB_OP_NOP        5'h00
`define CAB_OP_ADD        5'h01
`define CAB_OP_ADD_CARRY  5'h02
`define CAB_OP_SUB        5'h03
`define CAB_OP_SUB_CARRY  5'h04
`define CAB_OP_SUB_IMM    5'h05
`define CAB_OP_SUB_IMM_C  5'h06
`define CAB_OP_ADD_IMM_W  5'h07
`define CAB_OP_SUB_IMM_W  5'h08
`define CAB_OP_AND        5'h09
`define CAB_OP_AND_IMM    5'h0a
`define CAB_OP_OR         5'h0b
`define CAB_OP_OR_IMM     5'h0c
`define CAB_OP_EOR        5'h0d
`define CAB_OP_CLR_BITS   5'h0e
`define CAB_OP_SET_BITS   5'h0f
`define CAB_OP_TEST       5'h10
`define CAB_OP_MUL_U      5'h11
`define CAB_OP_MUL_S      5'h12
`define CAB_OP_MUL_SU     5'h13
`define CAB_OP_FRAC_U     5'h14
`define CAB_OP_FRAC_S     5'h15
`define CAB_OP_FRAC_SU    5'h16
`define CAB_OP_IND_JUMP   5'h17
`define CAB_OP_IND_CALL   5'h18

// ==========================================================
// Status flag bit positions
`define CAB_FLAG_C 0
`define CAB_FLAG_Z 1
`define CAB_FLAG_N 2
`define CAB_FLAG_V 3
`define CAB_FLAG_S 4
`define CAB_FLAG_H 5

// ==========================================================
// Cycle counts, all-ones mask and reset values
`define CAB_CYC_ONE   2'h1
`define CAB_CYC_WORD  2'h2
`define CAB_CYC_MUL   2'h2
`define CAB_CYC_JUMP  2'h2
`define CAB_CYC_CALL  2'h3
`define CAB_ALL_ONES  8'hff
`define CAB_RST_BYTE  8'h00
`define CAB_RST_WORD  16'h0000

`endif

/* cab_mult.v */
`timescale 1ns/100ps
// ==========================================================
// 8x8 multiplier with per-operand signedness
module cab_mult
(
   // Operands
   input wire [7:0] a,
   input wire [7:0] b,
   input wire a_signed,
   input wire b_signed,
   // Result
   output wire [15:0] product
);

   wire signed [8:0] a_ext;
   wire signed [8:0] b_ext;
   wire signed [17:0] full;

   // Nine-bit extension lets one signed multiplier cover all mixes
   assign a_ext = {a_signed & a[7], a};
   assign b_ext = {b_signed & b[7], b};
   assign full = a_ext * b_ext;
   assign product = full[15:0];

endmodule // cab_mult

/* cab_exec_unit.v */
`timescale 1ns/100ps
`include "cab_defines.vh"
// ==========================================================
// Arithmetic, logic, multiply and indirect branch execution
module cab_exec_unit
(
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // Request from the decoder
   input wire start,
   input wire [4:0] opcode,
   input wire [7:0] rd_val,
   input wire [7:0] rr_val,
   input wire [7:0] imm,
   input wire [15:0] pair_val,
   input wire [15:0] zptr,
   input wire [15:0] pc_cur,
   input wire [7:0] flags_in,
   output wire ready,
   output reg done,
   // Register file writes
   output reg rd_we,
   output reg [7:0] rd_data,
   output reg pair_we,
   output reg [15:0] pair_data,
   output reg prod_we,
   output reg [15:0] prod_data,
   // Program counter and stack
   output reg pc_we,
   output reg [15:0] pc_data,
   output reg push_we,
   output reg [15:0] push_data,
   // Status flags
   output reg [7:0] flag_we,
   output reg [7:0] flag_data
);

   reg [7:0] r8;
   reg [16:0] w17;
   reg [8:0] s9;
   reg [15:0] prod_adj;
   reg [7:0] fl;
   reg [7:0] fm;
   reg [1:0] cyc;
   reg wr8;
   reg wr16;
   reg wrp;
   reg wpc;
   reg mul_as;
   reg mul_bs;
   reg frac;
   reg [1:0] cnt_r;
   reg [1:0] cnt_nxt;
   reg [4:0] pend_r;
   reg [7:0] pend_fm_r;
   wire [15:0] prod_raw;
   wire cin;
   wire accept;

   assign cin = flags_in[`CAB_FLAG_C];
   assign ready = (cnt_r == 2'h0);
   assign accept = start & ready;

   // ==========================================================
   // Multiplier
   cab_mult u_mult
   (
      .a(rd_val),
      .b(rr_val),
      .a_signed(mul_as),
      .b_signed(mul_bs),
      .product(prod_raw)
   );

   // ==========================================================
   // Operation decode and flag generation
   always @*
   begin
      r8 = `CAB_RST_BYTE;
      w17 = 17'h00000;
      s9 = 9'h000;
      prod_adj = `CAB_RST_WORD;
      fl = flags_in;
      fm = 8'h00;
      cyc = `CAB_CYC_ONE;
      wr8 = 1'b0;
      wr16 = 1'b0;
      wrp = 1'b0;
      wpc = 1'b0;
      mul_as = 1'b0;
      mul_bs = 1'b0;
      frac = 1'b0;
      case (opcode)
         `CAB_OP_ADD, `CAB_OP_ADD_CARRY:
         begin
            s9 = {1'b0, rd_val} + {1'b0, rr_val} +
               {8'h00, cin & (opcode == `CAB_OP_ADD_CARRY)};
            r8 = s9[7:0];
            wr8 = 1'b1;
            fl[`CAB_FLAG_C] = s9[8];
            fl[`CAB_FLAG_H] = (rd_val[3] & rr_val[3]) |
               (rr_val[3] & ~r8[3]) | (~r8[3] & rd_val[3]);
            fl[`CAB_FLAG_V] = (rd_val[7] & rr_val[7] & ~r8[7]) |
               (~rd_val[7] & ~rr_val[7] & r8[7]);
            fl[`CAB_FLAG_N] = r8[7];
            fl[`CAB_FLAG_Z] = (r8 == 8'h00);
            fm = 8'h2f;
         end
         `CAB_OP_SUB, `CAB_OP_SUB_CARRY, `CAB_OP_SUB_IMM,
         `CAB_OP_SUB_IMM_C:
         begin
            // Immediate forms take the constant in place of Rr
            if (opcode == `CAB_OP_SUB_IMM || opcode == `CAB_OP_SUB_IMM_C)
               s9[7:0] = imm;
            else
               s9[7:0] = rr_val;
            fm[7:0] = s9[7:0];
            s9 = {1'b0, rd_val} - {1'b0, fm} -
               {8'h00, cin & (opcode == `CAB_OP_SUB_CARRY ||
               opcode == `CAB_OP_SUB_IMM_C)};
            r8 = s9[7:0];
            wr8 = 1'b1;
            fl[`CAB_FLAG_C] = s9[8];
            fl[`CAB_FLAG_H] = (~rd_val[3] & fm[3]) | (fm[3] & r8[3]) |
               (r8[3] & ~rd_val[3]);
            fl[`CAB_FLAG_V] = (rd_val[7] & ~fm[7] & ~r8[7]) |
               (~rd_val[7] & fm[7] & r8[7]);
            fl[`CAB_FLAG_N] = r8[7];
            // Carry forms keep Z chained so multi-byte compares work
            if (opcode == `CAB_OP_SUB_CARRY || opcode == `CAB_OP_SUB_IMM_C)
               fl[`CAB_FLAG_Z] = (r8 == 8'h00) & flags_in[`CAB_FLAG_Z];
            else
               fl[`CAB_FLAG_Z] = (r8 == 8'h00);
            fm = 8'h2f;
         end
         `CAB_OP_ADD_IMM_W, `CAB_OP_SUB_IMM_W:
         begin
            if (opcode == `CAB_OP_ADD_IMM_W)
               w17 = {1'b0, pair_val} + {11'h000, imm[5:0]};
            else
               w17 = {1'b0, pair_val} - {11'h000, imm[5:0]};
            wr16 = 1'b1;
            cyc = `CAB_CYC_WORD;
            fl[`CAB_FLAG_C] = w17[16];
            if (opcode == `CAB_OP_ADD_IMM_W)
               fl[`CAB_FLAG_V] = ~pair_val[15] & w17[15];
            else
               fl[`CAB_FLAG_V] = pair_val[15] & ~w17[15];
            fl[`CAB_FLAG_N] = w17[15];
            fl[`CAB_FLAG_Z] = (w17[15:0] == 16'h0000);
            fl[`CAB_FLAG_S] = w17[15] ^ fl[`CAB_FLAG_V];
            fm = 8'h1f;
         end
         `CAB_OP_AND, `CAB_OP_AND_IMM, `CAB_OP_OR, `CAB_OP_OR_IMM,
         `CAB_OP_EOR, `CAB_OP_CLR_BITS, `CAB_OP_SET_BITS, `CAB_OP_TEST:
         begin
            case (opcode)
               `CAB_OP_AND: r8 = rd_val & rr_val;
               `CAB_OP_AND_IMM: r8 = rd_val & imm;
               `CAB_OP_OR: r8 = rd_val | rr_val;
               `CAB_OP_OR_IMM: r8 = rd_val | imm;
               `CAB_OP_EOR: r8 = rd_val ^ rr_val;
               `CAB_OP_CLR_BITS: r8 = rd_val & (`CAB_ALL_ONES - imm);
               `CAB_OP_SET_BITS: r8 = rd_val | imm;
               default: r8 = rd_val & rd_val;
            endcase
            wr8 = 1'b1;
            fl[`CAB_FLAG_V] = 1'b0;
            fl[`CAB_FLAG_N] = r8[7];
            fl[`CAB_FLAG_Z] = (r8 == 8'h00);
            fm = 8'h0e;
         end
         `CAB_OP_MUL_U, `CAB_OP_MUL_S, `CAB_OP_MUL_SU, `CAB_OP_FRAC_U,
         `CAB_OP_FRAC_S, `CAB_OP_FRAC_SU:
         begin
            mul_as = (opcode == `CAB_OP_MUL_S) | (opcode == `CAB_OP_MUL_SU) |
               (opcode == `CAB_OP_FRAC_S) | (opcode == `CAB_OP_FRAC_SU);
            mul_bs = (opcode == `CAB_OP_MUL_S) | (opcode == `CAB_OP_FRAC_S);
            frac = (opcode == `CAB_OP_FRAC_U) | (opcode == `CAB_OP_FRAC_S) |
               (opcode == `CAB_OP_FRAC_SU);
            if (frac)
               prod_adj = {prod_raw[14:0], 1'b0};
            else
               prod_adj = prod_raw;
            wrp = 1'b1;
            cyc = `CAB_CYC_MUL;
            // Carry is the product's top bit before any shift
            fl[`CAB_FLAG_C] = prod_raw[15];
            fl[`CAB_FLAG_Z] = (prod_adj == 16'h0000);
            fm = 8'h03;
         end
         `CAB_OP_IND_JUMP:
         begin
            wpc = 1'b1;
            cyc = `CAB_CYC_JUMP;
         end
         `CAB_OP_IND_CALL:
         begin
            wpc = 1'b1;
            cyc = `CAB_CYC_CALL;
         end
         default:
         begin
            cyc = `CAB_CYC_ONE;
         end
      endcase
   end

   // ==========================================================
   // Busy counter: data lands at accept, strobes at the last cycle
   always @*
   begin
      cnt_nxt = cnt_r;
      if (accept)
         cnt_nxt = cyc - 2'h1;
      else if (cnt_r != 2'h0)
         cnt_nxt = cnt_r - 2'h1;
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_r <= 2'h0;
         pend_r <= 5'h00;
         pend_fm_r <= 8'h00;
         done <= 1'b0;
         rd_we <= 1'b0;
         pair_we <= 1'b0;
         prod_we <= 1'b0;
         pc_we <= 1'b0;
         push_we <= 1'b0;
         flag_we <= 8'h00;
         rd_data <= `CAB_RST_BYTE;
         pair_data <= `CAB_RST_WORD;
         prod_data <= `CAB_RST_WORD;
         pc_data <= `CAB_RST_WORD;
         push_data <= `CAB_RST_WORD;
         flag_data <= `CAB_RST_BYTE;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         done <= 1'b0;
         rd_we <= 1'b0;
         pair_we <= 1'b0;
         prod_we <= 1'b0;
         pc_we <= 1'b0;
         push_we <= 1'b0;
         flag_we <= 8'h00;
         if (accept)
         begin
            rd_data <= r8;
            pair_data <= w17[15:0];
            prod_data <= prod_adj;
            pc_data <= zptr;
            push_data <= pc_cur + 16'h0001;
            flag_data <= fl;
            pend_r <= {opcode == `CAB_OP_IND_CALL, wpc, wrp, wr16, wr8};
            pend_fm_r <= fm;
         end
         // Strobes fire on the final cycle of the operation
         if ((accept && cyc == `CAB_CYC_ONE) || cnt_r == 2'h1)
         begin
            done <= 1'b1;
            if (accept)
            begin
               rd_we <= wr8;
               flag_we <= fm;
            end
            else
            begin
               rd_we <= pend_r[0];
               pair_we <= pend_r[1];
               prod_we <= pend_r[2];
               pc_we <= pend_r[3];
               push_we <= pend_r[4];
               flag_we <= pend_fm_r;
            end
         end
      end
   end

endmodule // cab_exec_unit

/* cab_exec_props.sv */
`timescale 1ns/100ps
`include "cab_defines.vh"
// ==========================================================
// Port-level checks of the execution unit
module cab_exec_props
(
   // Clock and reset
   input logic clock,
   input logic rst_b,
   // Request
   input logic start,
   input logic [4:0] opcode,
   input logic [7:0] rd_val,
   input logic [7:0] rr_val,
   input logic [7:0] imm,
   input logic [15:0] pair_val,
   input logic [15:0] zptr,
   input logic [7:0] flags_in,
   input logic ready,
   // Results
   input logic done,
   input logic rd_we,
   input logic [7:0] rd_data,
   input logic pair_we,
   input logic [15:0] pair_data,
   input logic prod_we,
   input logic [15:0] prod_data,
   input logic pc_we,
   input logic [15:0] pc_data,
   input logic push_we,
   input logic [7:0] flag_we,
   input logic [7:0] flag_data
);
   // Accepted request
   wire go = start && ready;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   property p_adc;
      go && opcode == `CAB_OP_ADD_CARRY |=> done && rd_we && flag_we == 8'h2f
      && rd_data == $past(rd_val) + $past(rr_val) + $past(flags_in[0]);
   endproperty
   a_adc: assert property (p_adc) else $error("add carry bad");
   property p_sub_carry;
      go && opcode == `CAB_OP_SUB_CARRY |=> rd_we
      && rd_data == $past(rd_val) - $past(rr_val) - $past(flags_in[0]);
   endproperty
   a_sub_carry: assert property (p_sub_carry) else $error("sub carry bad");
   property p_word;
      go && opcode == `CAB_OP_ADD_IMM_W |=> !ready ##1 done && pair_we
      && flag_we == 8'h1f
      && pair_data == $past(pair_val, 2) + $past(imm[5:0], 2);
   endproperty
   a_word: assert property (p_word) else $error("word add bad");
   property p_subw;
      go && opcode == `CAB_OP_SUB_IMM_W |=> !done ##1 pair_we
      && pair_data == $past(pair_val, 2) - $past(imm[5:0], 2);
   endproperty
   a_subw: assert property (p_subw) else $error("word sub bad");
   property p_and;
      go && opcode == `CAB_OP_AND_IMM |=> flag_we == 8'h0e && !flag_data[3]
      && rd_data == ($past(rd_val) & $past(imm));
   endproperty
   a_and: assert property (p_and) else $error("and bad");
   property p_mul;
      go && opcode == `CAB_OP_MUL_U |=> !done ##1 done && prod_we
      && flag_we == 8'h03 && prod_data == $past(rd_val, 2) * $past(rr_val, 2);
   endproperty
   a_mul: assert property (p_mul) else $error("mul bad");
   property p_frac_mul;
      go && opcode == `CAB_OP_FRAC_U |=> !done ##1 prod_we
      && prod_data == ({8'h00, $past(rd_val, 2)} * $past(rr_val, 2)) << 1;
   endproperty
   a_frac_mul: assert property (p_frac_mul) else $error("frac mul bad");
   property p_ind_jump;
      go && opcode == `CAB_OP_IND_JUMP |=> !pc_we ##1 pc_we
      && flag_we == 8'h00 && pc_data == $past(zptr, 2);
   endproperty
   a_ind_jump: assert property (p_ind_jump) else $error("jump bad");
   property p_ind_call;
      go && opcode == `CAB_OP_IND_CALL |=> !pc_we ##1 !pc_we ##1 pc_we
      && push_we && pc_data == $past(zptr, 3);
   endproperty
   a_ind_call: assert property (p_ind_call) else $error("call bad");
   property p_sign;
      flag_we[4] |-> flag_data[4] == (flag_data[2] ^ flag_data[3]);
   endproperty
   a_sign: assert property (p_sign) else $error("sign bad");
   c_mul: cover property (go && opcode == `CAB_OP_MUL_S);
   c_call: cover property (go && opcode == `CAB_OP_IND_CALL);
   c_word: cover property (go && opcode == `CAB_OP_SUB_IMM_W);
endmodule // cab_exec_props

/* cab_sreg_model.sv */
`timescale 1ns/100ps
// ==========================================================
// Status register on the core side of the unit
module cab_sreg_model
(
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // Writes
   input wire [7:0] flag_we,
   input wire [7:0] flag_data,
   input wire set_en,
   input wire [7:0] set_val,
   // Flags back to the unit
   output reg [7:0] sreg_r
);
   // Masked write so flags the op does not own survive
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         sreg_r <= 8'h00;
      else if (set_en)
         sreg_r <= set_val;
      else
         sreg_r <= (sreg_r & ~flag_we) | (flag_data & flag_we);
   end
endmodule // cab_sreg_model

/* cpu_arith_branch_unit_tb.sv */
`timescale 1ns/100ps
`include "cab_defines.vh"
// ==========================================================
// Directed bench of the execution unit
module cpu_arith_branch_unit_tb;
   reg clock, rst_b, start, set_en;
   reg [4:0] opcode;
   reg [7:0] rd_val, rr_val, imm, set_val;
   reg [15:0] pair_val, zptr, pc_cur;
   wire [7:0] flags_in, flag_we, flag_data, rd_data;
   wire [15:0] pair_data, prod_data, pc_data, push_data;
   wire ready, done, rd_we, pair_we, prod_we, pc_we, push_we;
   integer error_cnt, checks, cyc;
   // Unit and status register
   cab_exec_unit uut (.clock, .rst_b, .start, .opcode, .rd_val, .rr_val,
      .imm, .pair_val, .zptr, .pc_cur, .flags_in, .ready, .done, .rd_we,
      .rd_data, .pair_we, .pair_data, .prod_we, .prod_data, .pc_we,
      .pc_data, .push_we, .push_data, .flag_we, .flag_data);
   cab_sreg_model sreg (.clock, .rst_b, .flag_we, .flag_data, .set_en,
      .set_val, .sreg_r(flags_in));
   // 200 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task chk(input [15:0] got, input [15:0] exp);
   begin
      checks = checks + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   // One request; cyc counts edges until done is seen
   task run(input [4:0] op, input [7:0] a, b, k, input [15:0] w);
   begin
      @(posedge clock);
      start <= 1'b1;
      opcode <= op;
      rd_val <= a;
      rr_val <= b;
      imm <= k;
      pair_val <= w;
      zptr <= w;
      @(posedge clock);
      start <= 1'b0;
      #1;
      cyc = 1;
      while (done !== 1'b1 && cyc < 8)
      begin
         @(posedge clock);
         #1;
         cyc = cyc + 1;
      end
   end
   endtask
   // Latency, value, flag mask and masked flag values
   task ckr(input integer n, input [15:0] d, got, input [7:0] we, f);
   begin
      chk(cyc, n);
      chk(got, d);
      chk(flag_we, we);
      chk(flag_data & we, f);
   end
   endtask
   task setc(input [7:0] v);
   begin
      @(posedge clock);
      set_en <= 1'b1;
      set_val <= v;
      @(posedge clock);
      set_en <= 1'b0;
   end
   endtask
   task t_arith;
   begin
      setc(8'h01);
      run(`CAB_OP_ADD_CARRY, 8'h7f, 8'h00, 8'h00, 16'h0000);
      ckr(1, 8'h80, rd_data, 8'h2f, 8'h2c);
      run(`CAB_OP_ADD, 8'h08, 8'h08, 8'h00, 16'h0000);
      ckr(1, 8'h10, rd_data, 8'h2f, 8'h20);
      setc(8'h03);
      run(`CAB_OP_SUB_CARRY, 8'h10, 8'h10, 8'h00, 16'h0000);
      ckr(1, 8'hff, rd_data, 8'h2f, 8'h25);
      run(`CAB_OP_SUB, 8'h10, 8'h10, 8'h00, 16'h0000);
      ckr(1, 8'h00, rd_data, 8'h2f, 8'h02);
      run(`CAB_OP_SUB_IMM, 8'h00, 8'h00, 8'h01, 16'h0000);
      ckr(1, 8'hff, rd_data, 8'h2f, 8'h25);
      run(`CAB_OP_SUB_IMM_C, 8'h80, 8'h00, 8'h00, 16'h0000);
      ckr(1, 8'h7f, rd_data, 8'h2f, 8'h28);
      run(`CAB_OP_ADD_IMM_W, 8'h00, 8'h00, 8'h01, 16'hffff);
      ckr(2, 16'h0000, pair_data, 8'h1f, 8'h03);
      chk(pair_we, 1'b1);
      run(`CAB_OP_SUB_IMM_W, 8'h00, 8'h00, 8'h01, 16'h8000);
      ckr(2, 16'h7fff, pair_data, 8'h1f, 8'h18);
      $display("t_arith done");
   end
   endtask
   task lg(input [4:0] op, input [7:0] d, f);
   begin
      run(op, 8'hc3, 8'h3c, 8'h3c, 16'h0000);
      ckr(1, d, rd_data, 8'h0e, f);
      chk(rd_we, 1'b1);
   end
   endtask
   task t_logic;
   begin
      lg(`CAB_OP_AND_IMM, 8'h00, 8'h02);
      lg(`CAB_OP_OR_IMM, 8'hff, 8'h04);
      lg(`CAB_OP_CLR_BITS, 8'hc3, 8'h04);
      lg(`CAB_OP_SET_BITS, 8'hff, 8'h04);
      lg(`CAB_OP_TEST, 8'hc3, 8'h04);
      lg(`CAB_OP_AND, 8'h00, 8'h02);
      lg(`CAB_OP_OR, 8'hff, 8'h04);
      lg(`CAB_OP_EOR, 8'hff, 8'h04);
      $display("t_logic done");
   end
   endtask
   task ml(input [4:0] op, input [7:0] a, b, input [15:0] p, input [7:0] f);
   begin
      run(op, a, b, 8'h00, 16'h0000);
      ckr(2, p, prod_data, 8'h03, f);
      chk(prod_we, 1'b1);
   end
   endtask
   task t_mul;
   begin
      ml(`CAB_OP_MUL_U, 8'hff, 8'hff, 16'hfe01, 8'h01);
      ml(`CAB_OP_MUL_U, 8'h00, 8'h55, 16'h0000, 8'h02);
      ml(`CAB_OP_MUL_S, 8'hff, 8'hff, 16'h0001, 8'h00);
      ml(`CAB_OP_MUL_SU, 8'hff, 8'h02, 16'hfffe, 8'h01);
      ml(`CAB_OP_FRAC_U, 8'h80, 8'h80, 16'h8000, 8'h00);
      ml(`CAB_OP_FRAC_S, 8'h80, 8'h80, 16'h8000, 8'h00);
      ml(`CAB_OP_FRAC_SU, 8'h80, 8'h40, 16'hc000, 8'h01);
      $display("t_mul done");
   end
   endtask
   task t_jump;
   begin
      run(`CAB_OP_IND_JUMP, 8'h00, 8'h00, 8'h00, 16'h1234);
      ckr(2, 16'h1234, pc_data, 8'h00, 8'h00);
      chk(pc_we, 1'b1);
      run(`CAB_OP_IND_CALL, 8'h00, 8'h00, 8'h00, 16'h5678);
      ckr(3, 16'h5678, pc_data, 8'h00, 8'h00);
      chk(push_we, 1'b1);
      chk(pc_we, 1'b1);
      chk(push_data, 16'h0101);
      $display("t_jump done");
   end
   endtask
   task close_out;
   begin
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   // Main sequence
   initial
   begin
      error_cnt = 0;
      checks = 0;
      cyc = 0;
      rst_b = 1'b0;
      start = 1'b0;
      set_en = 1'b0;
      set_val = 8'h00;
      opcode = 5'h00;
      rd_val = 8'h00;
      rr_val = 8'h00;
      imm = 8'h00;
      pair_val = 16'h0000;
      zptr = 16'h0000;
      pc_cur = 16'h0100;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      t_arith;
      t_logic;
      t_mul;
      t_jump;
      close_out;
   end
   // Watchdog, several times the expected run
   initial
   begin
      #5000;
      error_cnt = error_cnt + 1;
      close_out;
   end
endmodule // cpu_arith_branch_unit_tb
bind cab_exec_unit cab_exec_props chk_i (.clock, .rst_b, .start, .opcode,
   .rd_val, .rr_val, .imm, .pair_val, .zptr, .flags_in, .ready, .done,
   .rd_we, .rd_data, .pair_we, .pair_data, .prod_we, .prod_data, .pc_we,
   .pc_data, .push_we, .flag_we, .flag_data);
